//--- logic/pbm_pkg.sv
// constants for the port B pin function selector
// Overview of operation
// (RULE1) pin 15: gpio, motor pulse, serial2 clock
// (RULE2) pin 14: gpio, serial1 clock, timer clocks
// (RULE3) unused bits read zero, written zero
// (RULE4) pin 13: gpio or serial0 clock
// (RULE5) pin 12: gpio, timer clock, break trigger
// (RULE6) pin 11: gpio, serial4 rx, can rx, oneshot
// (RULE7) pin 10: gpio, serial4 tx, can tx, oneshot
// (RULE8) pin 9: gpio, serial3 rx, oneshot f
// (RULE9) pin 8: gpio, serial3 tx, oneshot e
// (RULE10) pin 7: gpio, pwm7 d, oneshot d
// (RULE11) pin 6: gpio, pwm7 c, oneshot c
// (RULE12) pin 5: gpio, pwm7 b, oneshot b
// (RULE13) pin 4: gpio, pwm7 a, oneshot a
// (RULE14) pin 3: gpio or pwm6 d
// (RULE15) pins 2..0: gpio or pwm6 c,b,a
// (RULE16) power-on reset clears both registers
// (RULE17) each pin steered by its selected source
package pbm_pkg;
    localparam int          ADDR_W         = 4;
    localparam logic [3:0]  UPPER_SEL_ADDR = 4'h0;
    localparam logic [3:0]  LOWER_SEL_ADDR = 4'h2;
    localparam logic [15:0] SEL_RESET      = 16'h0000;
    // writable bits; the rest are reserved and read zero
    localparam logic [15:0] UPPER_SEL_MASK = 16'hF7FF;
    localparam logic [15:0] LOWER_SEL_MASK = 16'hFF55;
    localparam logic [1:0]  SEL_GPIO       = 2'h0;
    localparam logic [1:0]  SEL_ALT1       = 2'h1;
    localparam logic [1:0]  SEL_ALT2       = 2'h2;
    localparam logic [1:0]  SEL_ALT3       = 2'h3;
endpackage

//--- logic/pbm_sel_reg.sv
// one function select register with reserved bits held at zero
`timescale 1ns/1ps
module pbm_sel_reg
    import pbm_pkg::*;
#(
    parameter logic [15:0] MASK = 16'hFFFF
) (
    input  wire logic        clk,   // system clock
    input  wire logic        rst_n, // power-on reset, active low
    input  wire logic        wr,    // write enable
    input  wire logic [15:0] wdata, // write data
    output logic      [15:0] q      // stored value
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= SEL_RESET; // RULE16
        end else if (wr) begin
            q <= wdata & MASK; // RULE3
        end
    end
endmodule

//--- logic/pbm_pin_steer.sv
// steers one pin from up to four sources selected by a 2-bit code
`timescale 1ns/1ps
module pbm_pin_steer
    import pbm_pkg::*;
(
    input  wire logic [1:0] sel,    // function code
    input  wire logic [3:0] src_o,  // output value per code
    input  wire logic [3:0] src_oe, // output enable per code
    input  wire logic       pin_i,  // pin level
    output logic            pin_o,  // pin output value
    output logic            pin_oe, // pin output enable
    output logic      [3:0] dst_i   // pin level gated to each code's input
);
    always_comb begin
        pin_o  = src_o[sel]; // RULE17
        pin_oe = src_oe[sel]; // RULE17
        dst_i  = 4'h0;
        dst_i[sel] = pin_i; // RULE17
    end
endmodule

//--- logic/pbm_top.sv
// port B pin function selector: registers, steering and registered pin outputs
`timescale 1ns/1ps
module pbm_top
    import pbm_pkg::*;
(
    input  wire logic              MCLK,         // system clock, 40 MHz
    input  wire logic              RST_N,        // power-on reset, active low
    input  wire logic [ADDR_W-1:0] ADDR,         // register address
    input  wire logic [15:0]       WDATA,        // write data
    input  wire logic              WR,           // write strobe
    input  wire logic              RD,           // read strobe
    output logic      [15:0]       RDATA,        // read data, cycle after RD
    input  wire logic [15:0]       PIN_I,        // pad levels
    output logic      [15:0]       PIN_O,        // pad output values
    output logic      [15:0]       PIN_OE,       // pad output enables
    input  wire logic [15:0]       GPIO_O,       // general i/o output values
    input  wire logic [15:0]       GPIO_OE,      // general i/o directions
    output logic      [15:0]       GPIO_I,       // general i/o input levels
    input  wire logic              MOTOR_PULSE_OUT_5,
    input  wire logic [2:0]        SERIAL_CLOCK_O,  // serial2/1/0 clock out, index = channel
    input  wire logic [2:0]        SERIAL_CLOCK_OE, // serial clock drive enables
    output logic      [2:0]        SERIAL_CLOCK_I,  // serial clock in
    output logic                   TIMER_EXT_CLOCK_A,   // timer clock A in
    output logic                   TIMER_EXT_CLOCK_B,   // timer clock B in
    output logic                   TIMER_EDGE_INPUT_10, // timer edge in
    input  wire logic              BREAK_TRIGGER_OUT,   // break trigger pulse
    output logic                   SERIAL4_RECEIVE_IN,  // serial4 rx
    input  wire logic              SERIAL4_TRANSMIT_OUT, // serial4 tx
    output logic                   SERIAL3_RECEIVE_IN,  // serial3 rx
    input  wire logic              SERIAL3_TRANSMIT_OUT, // serial3 tx
    output logic                   CAN0_RECEIVE_IN,     // can rx
    input  wire logic              CAN0_TRANSMIT_OUT,   // can tx
    input  wire logic [7:0]        ONESHOT_OUT,  // one-shot outputs a..h in bits 0..7
    input  wire logic [3:0]        PWM7_OUT,     // pwm7 a..d
    input  wire logic [3:0]        PWM6_OUT      // pwm6 a..d
);
    logic [15:0] upper_sel;
    logic [15:0] lower_sel;
    logic [1:0]  sel      [16];
    logic [3:0]  src_o    [16];
    logic [3:0]  src_oe   [16];
    logic [3:0]  dst_i    [16];
    logic [15:0] next_pin_o;
    logic [15:0] next_pin_oe;

    pbm_sel_reg #(.MASK(UPPER_SEL_MASK)) u_upper (
        .clk   (MCLK),
        .rst_n (RST_N),
        .wr    (WR && ADDR == UPPER_SEL_ADDR),
        .wdata (WDATA),
        .q     (upper_sel)
    );
    pbm_sel_reg #(.MASK(LOWER_SEL_MASK)) u_lower (
        .clk   (MCLK),
        .rst_n (RST_N),
        .wr    (WR && ADDR == LOWER_SEL_ADDR),
        .wdata (WDATA),
        .q     (lower_sel)
    );

    // unmapped addresses read zero; masked bits already zero
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            case (ADDR)
                UPPER_SEL_ADDR: RDATA <= upper_sel; // RULE3
                LOWER_SEL_ADDR: RDATA <= lower_sel; // RULE3
                default:        RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // code 11 drives nothing and feeds no input, except on pin 14 (timer edge in) and pins 11 and 10 (one-shot out)
    always_comb begin
        for (int p = 0; p < 16; p++) begin
            src_o[p]  = 4'h0;
            src_oe[p] = 4'h0;
            src_o[p][SEL_GPIO]  = GPIO_O[p];
            src_oe[p][SEL_GPIO] = GPIO_OE[p];
        end
        sel[15] = upper_sel[15:14]; // RULE1
        src_o[15][SEL_ALT1] = MOTOR_PULSE_OUT_5;
        src_oe[15][SEL_ALT1] = 1'b1;
        src_o[15][SEL_ALT2] = SERIAL_CLOCK_O[2];
        src_oe[15][SEL_ALT2] = SERIAL_CLOCK_OE[2];
        sel[14] = upper_sel[13:12]; // RULE2
        src_o[14][SEL_ALT1] = SERIAL_CLOCK_O[1];
        src_oe[14][SEL_ALT1] = SERIAL_CLOCK_OE[1];
        sel[13] = {1'b0, upper_sel[10]}; // RULE4
        src_o[13][SEL_ALT1] = SERIAL_CLOCK_O[0];
        src_oe[13][SEL_ALT1] = SERIAL_CLOCK_OE[0];
        sel[12] = upper_sel[9:8]; // RULE5
        src_o[12][SEL_ALT2] = BREAK_TRIGGER_OUT;
        src_oe[12][SEL_ALT2] = 1'b1;
        sel[11] = upper_sel[7:6]; // RULE6
        src_o[11][SEL_ALT3] = ONESHOT_OUT[7];
        src_oe[11][SEL_ALT3] = 1'b1;
        sel[10] = upper_sel[5:4]; // RULE7
        src_o[10][SEL_ALT1] = SERIAL4_TRANSMIT_OUT;
        src_o[10][SEL_ALT2] = CAN0_TRANSMIT_OUT;
        src_o[10][SEL_ALT3] = ONESHOT_OUT[6];
        src_oe[10][3:1] = 3'h7;
        sel[9] = upper_sel[3:2]; // RULE8
        src_o[9][SEL_ALT2] = ONESHOT_OUT[5];
        src_oe[9][SEL_ALT2] = 1'b1;
        sel[8] = upper_sel[1:0]; // RULE9
        src_o[8][SEL_ALT1] = SERIAL3_TRANSMIT_OUT;
        src_o[8][SEL_ALT2] = ONESHOT_OUT[4];
        src_oe[8][2:1] = 2'h3;
        // pins 7..4 share one layout: pwm7 on code 01, one-shot on 10
        for (int p = 4; p < 8; p++) begin
            sel[p] = lower_sel[2*p+1 -: 2]; // RULE10 RULE11 RULE12 RULE13
            src_o[p][SEL_ALT1] = PWM7_OUT[p-4];
            src_o[p][SEL_ALT2] = ONESHOT_OUT[p-4];
            src_oe[p][2:1] = 2'h3;
        end
        // pins 3..0: single bit at even position
        for (int p = 0; p < 4; p++) begin
            sel[p] = {1'b0, lower_sel[2*p]}; // RULE14 RULE15
            src_o[p][SEL_ALT1] = PWM6_OUT[p];
            src_oe[p][SEL_ALT1] = 1'b1;
        end
    end

    for (genvar g = 0; g < 16; g++) begin : g_pin
        pbm_pin_steer u_steer (
            .sel    (sel[g]),
            .src_o  (src_o[g]),
            .src_oe (src_oe[g]),
            .pin_i  (PIN_I[g]),
            .pin_o  (next_pin_o[g]),
            .pin_oe (next_pin_oe[g]),
            .dst_i  (dst_i[g])
        );
    end

    // outputs registered for clean pad timing; costs one cycle of latency
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            PIN_O  <= 16'h0000;
            PIN_OE <= 16'h0000;
        end else begin
            PIN_O  <= next_pin_o; // RULE17
            PIN_OE <= next_pin_oe; // RULE17
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            GPIO_I              <= 16'h0000;
            SERIAL_CLOCK_I      <= 3'h0;
            TIMER_EXT_CLOCK_A   <= 1'b0;
            TIMER_EXT_CLOCK_B   <= 1'b0;
            TIMER_EDGE_INPUT_10 <= 1'b0;
            SERIAL4_RECEIVE_IN  <= 1'b0;
            SERIAL3_RECEIVE_IN  <= 1'b0;
            CAN0_RECEIVE_IN     <= 1'b0;
        end else begin
            for (int p = 0; p < 16; p++) begin
                GPIO_I[p] <= dst_i[p][SEL_GPIO]; // RULE17
            end
            SERIAL_CLOCK_I      <= {dst_i[15][SEL_ALT2], dst_i[14][SEL_ALT1], dst_i[13][SEL_ALT1]};
            TIMER_EXT_CLOCK_B   <= dst_i[14][SEL_ALT2]; // RULE2
            TIMER_EDGE_INPUT_10 <= dst_i[14][SEL_ALT3]; // RULE2
            TIMER_EXT_CLOCK_A   <= dst_i[12][SEL_ALT1]; // RULE5
            SERIAL4_RECEIVE_IN  <= dst_i[11][SEL_ALT1]; // RULE6
            CAN0_RECEIVE_IN     <= dst_i[11][SEL_ALT2]; // RULE6
            SERIAL3_RECEIVE_IN  <= dst_i[9][SEL_ALT1]; // RULE8
        end
    end
endmodule

//--- verif/pbm_props.sv
// assertions on the port B function selector ports
`timescale 1ns/1ps
module pbm_props
    import pbm_pkg::*;
(
    input wire logic              MCLK,                // clock
    input wire logic              RST_N,               // reset
    input wire logic [ADDR_W-1:0] ADDR,                // address
    input wire logic [15:0]       WDATA,               // write data
    input wire logic              WR,                  // write strobe
    input wire logic              RD,                  // read strobe
    input wire logic [15:0]       RDATA,               // read data
    input wire logic [15:0]       PIN_I,               // pad in
    input wire logic [15:0]       PIN_O,               // pad out
    input wire logic [15:0]       PIN_OE,              // pad enable
    input wire logic [15:0]       GPIO_O,              // gpio value
    input wire logic [15:0]       GPIO_OE,             // gpio direction
    input wire logic [2:0]        SERIAL_CLOCK_OE,     // serial clock enable
    input wire logic              TIMER_EDGE_INPUT_10, // timer edge in
    input wire logic              CAN0_RECEIVE_IN,     // can rx
    input wire logic [3:0]        PWM6_OUT             // pwm6 a..d
);
    logic [15:0] up;
    logic [15:0] lo;
    logic [1:0]  live;
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // shadow copies give each pin's code; live skips the edges whose past still sees reset
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            up   <= 16'h0000;
            lo   <= 16'h0000;
            live <= 2'h0;
        end else begin
            live <= {live[0], 1'h1};
            if (WR && ADDR == 4'h0) up <= WDATA & 16'hF7FF;
            if (WR && ADDR == 4'h2) lo <= WDATA & 16'hFF55;
        end
    end
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 16'h0000) else $error("read data not idle");
    a_read_upper: assert property ($past(RD) && $past(ADDR) == 4'h0 |-> RDATA == $past(up))
        else $error("upper select readback wrong");
    a_read_lower: assert property ($past(RD) && $past(ADDR) == 4'h2 |-> RDATA == $past(lo))
        else $error("lower select readback wrong");
    a_read_unmapped: assert property ($past(RD) && $past(ADDR) != 4'h0 && $past(ADDR) != 4'h2 |->
        RDATA == 16'h0000) else $error("unmapped read not zero");
    a_gpio_path: assert property (live[1] && $past(up[15:14]) == 2'h0 |-> PIN_OE[15] == $past(GPIO_OE[15]) &&
        (!PIN_OE[15] || PIN_O[15] == $past(GPIO_O[15]))) else $error("pin 15 gpio path wrong");
    a_pin15_reserved: assert property (live[1] && $past(up[15:14]) == 2'h3 |-> !PIN_OE[15])
        else $error("reserved code drives pin 15");
    a_serial0_clock_enable: assert property (live[1] && $past(up[10]) |-> PIN_OE[13] == $past(SERIAL_CLOCK_OE[0]))
        else $error("pin 13 serial clock enable wrong");
    a_edge_input: assert property (live[1] && $past(up[13:12]) == 2'h3 |->
        TIMER_EDGE_INPUT_10 == $past(PIN_I[14])) else $error("timer edge input wrong");
    a_can_rx_gate: assert property (live[1] |->
        CAN0_RECEIVE_IN == ($past(up[7:6]) == 2'h2 && $past(PIN_I[11]))) else $error("can receive gating wrong");
    a_pwm6_pin0: assert property (live[1] && $past(lo[0]) |-> PIN_OE[0] && PIN_O[0] == $past(PWM6_OUT[0]))
        else $error("pin 0 pwm path wrong");
endmodule
bind pbm_top pbm_props u_props (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .GPIO_O(GPIO_O), .GPIO_OE(GPIO_OE),
    .SERIAL_CLOCK_OE(SERIAL_CLOCK_OE), .TIMER_EDGE_INPUT_10(TIMER_EDGE_INPUT_10),
    .CAN0_RECEIVE_IN(CAN0_RECEIVE_IN), .PWM6_OUT(PWM6_OUT));

//--- verif/pbm_periph_model.sv
// stand-in for the on-chip peripherals and pads
`timescale 1ns/1ps
module pbm_periph_model (
    input  wire logic        clk,   // system clock
    input  wire logic        rst_n, // reset, active low
    output logic      [63:0] src    // peripheral and pad levels
);
    // rotate and invert so no source holds a stale level a check could miss
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src <= 64'h0F1E2D3C4B5A6978;
        end else begin
            src <= ~{src[0], src[63:1]};
        end
    end
endmodule

//--- verif/test_port_b_pin_function_select.sv
// self-checking bench for the port B function selector
`timescale 1ns/1ps
module test_port_b_pin_function_select;
    logic        MCLK = 1'h0;
    logic        RST_N = 1'h0;
    logic [3:0]  ADDR = 4'h0;
    logic [15:0] WDATA = 16'h0000;
    logic        WR = 1'h0;
    logic        RD = 1'h0;
    logic [15:0] RDATA, PIN_O, PIN_OE;
    logic        edge10, can_rx, o4;
    logic        tca, tcb, rx4, rx3;
    logic [2:0]  sclk_i;
    logic [15:0] gpio_i;
    logic [31:0] sw;
    logic [1:0]  e;
    logic [63:0] src, p;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          cyc = 0;
    always #12.5 MCLK = ~MCLK;
    pbm_periph_model PARTNER (.clk(MCLK), .rst_n(RST_N), .src(src));
    pbm_top DUT (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .PIN_I(src[15:0]), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .GPIO_O(src[31:16]), .GPIO_OE(src[47:32]),
        .GPIO_I(gpio_i), .MOTOR_PULSE_OUT_5(src[48]), .SERIAL_CLOCK_O(src[51:49]), .SERIAL_CLOCK_OE(src[54:52]),
        .SERIAL_CLOCK_I(sclk_i), .TIMER_EXT_CLOCK_A(tca), .TIMER_EXT_CLOCK_B(tcb), .TIMER_EDGE_INPUT_10(edge10),
        .BREAK_TRIGGER_OUT(src[55]), .SERIAL4_RECEIVE_IN(rx4), .SERIAL4_TRANSMIT_OUT(src[56]),
        .SERIAL3_RECEIVE_IN(rx3), .SERIAL3_TRANSMIT_OUT(src[57]), .CAN0_RECEIVE_IN(can_rx),
        .CAN0_TRANSMIT_OUT(src[58]), .ONESHOT_OUT(src[63:56]), .PWM7_OUT(src[27:24]), .PWM6_OUT(src[43:40]));
    // expected {enable, value} of one pad for its select code, from the source map wired above
    function automatic logic [1:0] exp_pin(input int n, input logic [1:0] code, input logic [63:0] s);
        if (code == 2'h0) begin
            return {s[32+n], s[16+n]};
        end
        case (n)
            15:         return (code == 2'h1) ? {1'h1, s[48]} : (code == 2'h2) ? {s[54], s[51]} : 2'h0;
            14:         return (code == 2'h1) ? {s[53], s[50]} : 2'h0;
            13:         return {s[52], s[49]};
            12:         return (code == 2'h2) ? {1'h1, s[55]} : 2'h0;
            11:         return (code == 2'h3) ? {1'h1, s[63]} : 2'h0;
            10:         return (code == 2'h1) ? {1'h1, s[56]} : (code == 2'h2) ? {1'h1, s[58]} : {1'h1, s[62]};
            9:          return (code == 2'h2) ? {1'h1, s[61]} : 2'h0;
            8:          return (code == 2'h1) ? {1'h1, s[57]} : (code == 2'h2) ? {1'h1, s[60]} : 2'h0;
            7, 6, 5, 4: return (code == 2'h1) ? {1'h1, s[20+n]} : (code == 2'h2) ? {1'h1, s[52+n]} : 2'h0;
            default:    return {1'h1, s[40+n]};
        endcase
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge MCLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'h1;
        @(posedge MCLK);
        WR <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge MCLK);
        ADDR <= a;
        RD   <= 1'h1;
        @(posedge MCLK);
        RD <= 1'h0;
        @(negedge MCLK);
        chk(RDATA, exp);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // p holds the sources the pin flops sampled at the last edge
    always @(posedge MCLK) begin
        p   <= src;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        repeat (5) @(posedge MCLK);
        RST_N <= 1'h1;
        rd(4'h0, 16'h0000);
        rd(4'h2, 16'h0000);
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'hF7FF);
        wr(4'h2, 16'hFFFF);
        rd(4'h2, 16'hFF55);
        wr(4'h6, 16'hFFFF);
        rd(4'h6, 16'h0000);
        rd(4'h2, 16'hFF55);
        for (int c = 0; c < 4; c++) begin
            // every two-bit field gets code c, each one-bit field its low bit; reserved bits written zero
            sw = {c[1:0], c[1:0], 1'h0, c[0], {5{c[1:0]}}, {4{c[1:0]}}, {4{1'h0, c[0]}}};
            wr(4'h0, sw[31:16]);
            wr(4'h2, sw[15:0]);
            @(posedge MCLK);
            @(negedge MCLK);
            o4 = (c == 1) ? p[24] : (c == 2) ? p[56] : (c == 0) ? p[20] & p[36] : 1'h0;
            chk({15'h0, PIN_OE[4]}, {15'h0, c == 1 || c == 2 || (c == 0 && p[36])});
            chk({15'h0, PIN_O[4] & PIN_OE[4]}, {15'h0, o4});
            chk({15'h0, can_rx}, {15'h0, c == 2 && p[11]});
            chk({15'h0, edge10}, {15'h0, c == 3 && p[14]});
            chk({13'h0, sclk_i}, {13'h0, c == 2 && p[15], c == 1 && p[14], c[0] && p[13]});
            chk({14'h0, tca, tcb}, {14'h0, c == 1 && p[12], c == 2 && p[14]});
            chk({14'h0, rx4, rx3}, {14'h0, c == 1 && p[11], c == 1 && p[9]});
            for (int n = 0; n < 16; n++) begin
                e = exp_pin(n, sw[2*n+1 -: 2], p);
                chk({14'h0, PIN_OE[n], PIN_O[n] & PIN_OE[n]}, {14'h0, e[1], e[0] & e[1]});
                chk({15'h0, gpio_i[n]}, {15'h0, sw[2*n+1 -: 2] == 2'h0 && p[n]});
            end
        end
        wr(4'h0, 16'h1234);
        RST_N <= 1'h0;
        @(posedge MCLK);
        RST_N <= 1'h1;
        rd(4'h0, 16'h0000);
        rd(4'h2, 16'h0000);
        results();
    end
endmodule
